// ---- core/mcsc_top.sv ----
// Main clock source control: pin mode, source select, run/stop, stabilization.
//
// Overview of operation
// - Pin-mode/gain register takes one write after reset
// - Pin bits decode port, crystal, or external clock
// - Select bit picks on-chip or high-speed source
// - Read-only status bit shows current main source
// - High-speed stop bit gates crystal or external clock
// - On-chip oscillator stop bit stops it
// - Run/stop register resets to C0H
// - Progress cleared by reset, STOP, stop bit
// - Counter starts on crystal start or STOP exit
// - Progress bits set top bit first, stay set
// - Counter stops at selected wait time
// - Wait excludes time before oscillation starts
// - Crystal held off until wait elapses; selection resets 07H
`timescale 1ns/1ns
`default_nettype none

module mcsc_top (
	input  wire logic        clk_i,
	input  wire logic        resetn_i,
	// CPU memory access
	input  wire logic [19:0] addr_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	input  wire logic [7:0]  wdata_i,
	output logic      [7:0]  rdata_o,
	// Power mode and crystal events
	input  wire logic        stop_enter_i,
	input  wire logic        stop_exit_i,
	input  wire logic        xtal_tick_i,
	input  wire logic        osc_started_i,
	// Clock and pad controls
	output logic             xtal_osc_en_o,
	output logic             oscillator_gain_o,
	output logic             ext_clk_en_o,
	output logic             crystal_input_pin_port_o,
	output logic             second_pin_port_o,
	output logic             onchip_osc_run_o,
	output logic             main_source_hs_o,
	output logic             hs_clock_ready_o
);

	// ==========================================================
	// Storage
	logic [7:0] pin_mode_and_gain_q;
	logic       pin_mode_written_q;
	logic       high_speed_stop_bit_q;
	logic       onchip_osc_stop_bit_q;
	logic       main_source_select_bit_q;
	logic       main_source_status_bit_q;
	logic [2:0] stabilization_time_selection_q;
	logic       stop_mode_q;
	logic [7:0] rdata_q;

	logic [7:0] stabilization_progress_w;
	logic       stab_done_w;
	logic       stab_clear_w;
	logic       stab_start_w;
	logic       wr_pin_w;
	logic       wr_run_stop_w;
	logic       wr_select_w;
	logic       wr_time_sel_w;
	logic       crystal_mode_w;
	logic       ext_clock_mode_w;
	logic       hs_ready_w;

	mcsc_pkg::mcsc_pin_mode_t pin_mode_w;

	// ==========================================================
	// Address decode
	assign wr_pin_w      = wr_i && (addr_i == mcsc_pkg::ADDR_PIN_MODE_AND_GAIN);
	assign wr_run_stop_w = wr_i && (addr_i == mcsc_pkg::ADDR_CLOCK_RUN_STOP_CONTROL);
	assign wr_select_w   = wr_i && (addr_i == mcsc_pkg::ADDR_MAIN_CLOCK_SELECT);
	assign wr_time_sel_w = wr_i && (addr_i == mcsc_pkg::ADDR_STABILIZATION_TIME_SEL);

	// ==========================================================
	// Pin-mode and gain register, write once
	// A runaway program cannot reconfigure the pads later: the first write
	// wins, every other write is dropped until the next reset
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pin_mode_and_gain_q <= mcsc_pkg::RST_PIN_MODE_AND_GAIN;
			pin_mode_written_q  <= 1'b0;
		end else if (wr_pin_w && !pin_mode_written_q) begin
			pin_mode_and_gain_q <= wdata_i & mcsc_pkg::MASK_PIN_MODE_AND_GAIN;
			pin_mode_written_q  <= 1'b1;
		end
	end

	// Pin mode decode
	assign pin_mode_w = mcsc_pkg::mcsc_pin_mode_t'({
		pin_mode_and_gain_q[mcsc_pkg::BIT_EXTERNAL_CLOCK_PIN],
		pin_mode_and_gain_q[mcsc_pkg::BIT_CRYSTAL_SELECT]});

	always_comb begin
		crystal_mode_w   = 1'b0;
		ext_clock_mode_w = 1'b0;
		case (pin_mode_w)
			mcsc_pkg::MCSC_PIN_CRYSTAL: begin
				crystal_mode_w = 1'b1;
			end
			mcsc_pkg::MCSC_PIN_EXTCLOCK: begin
				ext_clock_mode_w = 1'b1;
			end
			default: begin
				crystal_mode_w   = 1'b0;
				ext_clock_mode_w = 1'b0;
			end
		endcase
	end

	// ==========================================================
	// Run/stop control register
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			high_speed_stop_bit_q <= mcsc_pkg::RST_CLOCK_RUN_STOP_CONTROL[mcsc_pkg::BIT_HIGH_SPEED_STOP];
			onchip_osc_stop_bit_q <= mcsc_pkg::RST_CLOCK_RUN_STOP_CONTROL[mcsc_pkg::BIT_ONCHIP_OSC_STOP];
		end else if (wr_run_stop_w) begin
			high_speed_stop_bit_q <= wdata_i[mcsc_pkg::BIT_HIGH_SPEED_STOP];
			onchip_osc_stop_bit_q <= wdata_i[mcsc_pkg::BIT_ONCHIP_OSC_STOP];
		end
	end

	// Stabilization time selection
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			stabilization_time_selection_q <= mcsc_pkg::RST_STABILIZATION_TIME_SEL;
		end else if (wr_time_sel_w) begin
			stabilization_time_selection_q <= wdata_i[2:0];
		end
	end

	// STOP mode tracking; exit wins if both arrive together
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			stop_mode_q <= 1'b0;
		end else if (stop_exit_i) begin
			stop_mode_q <= 1'b0;
		end else if (stop_enter_i) begin
			stop_mode_q <= 1'b1;
		end
	end

	// ==========================================================
	// Stabilization counter control
	// A write that keeps the stop bit at 0 must not restart the wait,
	// so the start needs a real 1-to-0 change of the bit
	assign stab_clear_w = stop_enter_i
		|| (wr_run_stop_w && wdata_i[mcsc_pkg::BIT_HIGH_SPEED_STOP]);
	assign stab_start_w = crystal_mode_w && !stab_clear_w
		&& ((wr_run_stop_w && high_speed_stop_bit_q
			&& !wdata_i[mcsc_pkg::BIT_HIGH_SPEED_STOP])
		|| (stop_exit_i && !high_speed_stop_bit_q));

	mcsc_stab_counter #(
		.CNT_W (mcsc_pkg::STAB_CNT_W)
	) mcsc_stab_counter_inst (
		.clk_i         (clk_i),
		.resetn_i      (resetn_i),
		.clear_i       (stab_clear_w),
		.start_i       (stab_start_w),
		.tick_i        (xtal_tick_i),
		.osc_started_i (osc_started_i),
		.limit_sel_i   (stabilization_time_selection_q),
		.status_o      (stabilization_progress_w),
		.done_o        (stab_done_w)
	);

	// ==========================================================
	// High-speed clock readiness
	// The crystal is only usable once the selected wait has elapsed; an
	// external clock is taken as ready as soon as it is let through
	assign hs_ready_w = !stop_mode_q && !high_speed_stop_bit_q
		&& ((crystal_mode_w && stab_done_w) || ext_clock_mode_w);

	// ==========================================================
	// Main clock select and status
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			main_source_select_bit_q <= mcsc_pkg::RST_MAIN_CLOCK_SELECT[mcsc_pkg::BIT_MAIN_SOURCE_SELECT];
		end else if (wr_select_w) begin
			main_source_select_bit_q <= wdata_i[mcsc_pkg::BIT_MAIN_SOURCE_SELECT];
		end
	end

	// Status moves to the high-speed clock only once it is ready, so the
	// CPU is never switched onto an unstable crystal
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			main_source_status_bit_q <= mcsc_pkg::RST_MAIN_CLOCK_SELECT[mcsc_pkg::BIT_MAIN_SOURCE_STATUS];
		end else if (!main_source_select_bit_q) begin
			main_source_status_bit_q <= 1'b0;
		end else if (hs_ready_w) begin
			main_source_status_bit_q <= 1'b1;
		end
	end

	// ==========================================================
	// Clock and pad outputs
	assign xtal_osc_en_o            = crystal_mode_w && !high_speed_stop_bit_q && !stop_mode_q;
	assign ext_clk_en_o             = ext_clock_mode_w && !high_speed_stop_bit_q && !stop_mode_q;
	assign oscillator_gain_o        = pin_mode_and_gain_q[mcsc_pkg::BIT_OSCILLATOR_GAIN];
	assign crystal_input_pin_port_o = !crystal_mode_w;
	assign second_pin_port_o        = !crystal_mode_w && !ext_clock_mode_w;
	assign onchip_osc_run_o         = !onchip_osc_stop_bit_q && !stop_mode_q;
	assign main_source_hs_o         = main_source_status_bit_q;
	assign hs_clock_ready_o         = hs_ready_w;

	// ==========================================================
	// Read data, registered; unmapped addresses read 00
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdata_q <= 8'h00;
		end else if (rd_i) begin
			case (addr_i)
				mcsc_pkg::ADDR_PIN_MODE_AND_GAIN: begin
					rdata_q <= pin_mode_and_gain_q;
				end
				mcsc_pkg::ADDR_CLOCK_RUN_STOP_CONTROL: begin
					rdata_q <= {high_speed_stop_bit_q, 1'b1, 5'h00, onchip_osc_stop_bit_q};
				end
				mcsc_pkg::ADDR_STABILIZATION_PROGRESS: begin
					rdata_q <= stabilization_progress_w;
				end
				mcsc_pkg::ADDR_STABILIZATION_TIME_SEL: begin
					rdata_q <= {5'h00, stabilization_time_selection_q};
				end
				mcsc_pkg::ADDR_MAIN_CLOCK_SELECT: begin
					rdata_q <= {2'h0, main_source_status_bit_q, main_source_select_bit_q, 4'h0};
				end
				default: begin
					rdata_q <= 8'h00;
				end
			endcase
		end
	end

	assign rdata_o = rdata_q;

	// ==========================================================
	// Checks
	chk_pin_first_write: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(wr_pin_w && !pin_mode_written_q)
		|=> (pin_mode_and_gain_q == ($past(wdata_i) & mcsc_pkg::MASK_PIN_MODE_AND_GAIN)))
		else $error("first pin-mode write was not stored");

	chk_pin_write_once: assert property (@(posedge clk_i) disable iff (!resetn_i)
		pin_mode_written_q |=> $stable(pin_mode_and_gain_q) && pin_mode_written_q)
		else $error("pin-mode register changed after its single write");

	chk_pad_decode: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(ext_clk_en_o || xtal_osc_en_o)
		|-> (pin_mode_and_gain_q[mcsc_pkg::BIT_CRYSTAL_SELECT] && !second_pin_port_o))
		else $error("clock enabled in input-port mode");

	chk_hs_stop_gates: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(wr_run_stop_w && wdata_i[mcsc_pkg::BIT_HIGH_SPEED_STOP])
		|=> (!xtal_osc_en_o && !ext_clk_en_o && stabilization_progress_w == 8'h00))
		else $error("high-speed clock or progress survived the stop bit");

	chk_onchip_stop: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(wr_run_stop_w && wdata_i[mcsc_pkg::BIT_ONCHIP_OSC_STOP]) |=> !onchip_osc_run_o)
		else $error("on-chip oscillator still running after stop");

	chk_run_stop_read: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(rd_i && addr_i == mcsc_pkg::ADDR_CLOCK_RUN_STOP_CONTROL) |=> rdata_o[6])
		else $error("run/stop register bit 6 read as 0");

	chk_status_follows: assert property (@(posedge clk_i) disable iff (!resetn_i)
		!main_source_select_bit_q |=> !main_source_status_bit_q)
		else $error("status bit high while on-chip source selected");

	chk_hold_off: assert property (@(posedge clk_i) disable iff (!resetn_i)
		$rose(main_source_status_bit_q) |-> $past(hs_ready_w) && $past(main_source_select_bit_q))
		else $error("switched to high-speed clock before it was ready");

	chk_stop_clears: assert property (@(posedge clk_i) disable iff (!resetn_i)
		stop_enter_i |=> stabilization_progress_w == 8'h00)
		else $error("progress not cleared by STOP entry");

	// A restart must begin the wait from nothing, or the CPU could switch early
	chk_start_from_zero: assert property (@(posedge clk_i) disable iff (!resetn_i)
		stab_start_w |=> (stabilization_progress_w == 8'h00 && !hs_ready_w))
		else $error("stabilization wait did not restart from zero");

	chk_stop_gates_osc: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(stop_enter_i && !stop_exit_i) |=> (!xtal_osc_en_o && !ext_clk_en_o && !onchip_osc_run_o))
		else $error("oscillator left running in STOP mode");

	chk_select_takes: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(wr_select_w && wdata_i[mcsc_pkg::BIT_MAIN_SOURCE_SELECT]) |=> main_source_select_bit_q)
		else $error("main source select bit not stored");

endmodule

`default_nettype wire

// ---- core/mcsc_pkg.sv ----
// Shared constants for the main clock source control block.
package mcsc_pkg;

	// ==========================================================
	// Register addresses (CPU data space)
	localparam logic [19:0] ADDR_PIN_MODE_AND_GAIN       = 20'hfffa0;
	localparam logic [19:0] ADDR_CLOCK_RUN_STOP_CONTROL  = 20'hfffa1;
	localparam logic [19:0] ADDR_STABILIZATION_PROGRESS  = 20'hfffa2;
	localparam logic [19:0] ADDR_STABILIZATION_TIME_SEL  = 20'hfffa3;
	localparam logic [19:0] ADDR_MAIN_CLOCK_SELECT       = 20'hfffa4;

	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_PIN_MODE_AND_GAIN      = 8'h00;
	localparam logic [7:0] RST_CLOCK_RUN_STOP_CONTROL = 8'hc0;
	localparam logic [7:0] RST_STABILIZATION_PROGRESS = 8'h00;
	localparam logic [2:0] RST_STABILIZATION_TIME_SEL = 3'h7;
	localparam logic [7:0] RST_MAIN_CLOCK_SELECT      = 8'h00;

	// ==========================================================
	// Field positions
	localparam int BIT_EXTERNAL_CLOCK_PIN = 7;
	localparam int BIT_CRYSTAL_SELECT     = 6;
	localparam int BIT_OSCILLATOR_GAIN    = 0;
	localparam int BIT_HIGH_SPEED_STOP    = 7;
	localparam int BIT_RUN_STOP_FIXED_ONE = 6;
	localparam int BIT_ONCHIP_OSC_STOP    = 0;
	localparam int BIT_MAIN_SOURCE_STATUS = 5;
	localparam int BIT_MAIN_SOURCE_SELECT = 4;

	// Writable bits of the pin-mode/gain register
	localparam logic [7:0] MASK_PIN_MODE_AND_GAIN = 8'hc1;

	// ==========================================================
	// Pin operation modes, {external_clock_pin_bit, crystal_select_bit}
	typedef enum logic [1:0] {
		MCSC_PIN_PORT_A   = 2'b00,
		MCSC_PIN_CRYSTAL  = 2'b01,
		MCSC_PIN_PORT_B   = 2'b10,
		MCSC_PIN_EXTCLOCK = 2'b11
	} mcsc_pin_mode_t;

	// ==========================================================
	// Stabilization steps: exponent of crystal cycles per step, step 0 in the lowest bits (listed last)
	localparam int          STAB_STEPS     = 8;
	localparam int          STAB_EXP_W     = 5;
	localparam logic [39:0] STAB_EXP_TABLE = {5'h12, 5'h11, 5'h0f, 5'h0d,
	                                          5'h0b, 5'h0a, 5'h09, 5'h08};
	localparam int          STAB_CNT_W     = 19;

endpackage

// ---- core/mcsc_stab_counter.sv ----
// Crystal oscillation stabilization counter with thermometer status.
`timescale 1ns/1ns
`default_nettype none

module mcsc_stab_counter #(
	parameter int CNT_W = mcsc_pkg::STAB_CNT_W
) (
	input  wire logic       clk_i,
	input  wire logic       resetn_i,
	input  wire logic       clear_i,
	input  wire logic       start_i,
	input  wire logic       tick_i,
	input  wire logic       osc_started_i,
	input  wire logic [2:0] limit_sel_i,
	output logic      [7:0] status_o,
	output logic            done_o
);

	// ==========================================================
	// Elaboration check
	if (CNT_W < mcsc_pkg::STAB_CNT_W) begin : g_width_check
		$error("mcsc_stab_counter: CNT_W too small for the longest wait");
	end

	logic [CNT_W-1:0] count_q;
	logic             run_q;
	logic [CNT_W-1:0] limit_w;
	logic [4:0]       limit_exp_w;

	// Selected stop point, a power of two of crystal cycles
	assign limit_exp_w = mcsc_pkg::STAB_EXP_TABLE[limit_sel_i*mcsc_pkg::STAB_EXP_W +: 5];
	assign limit_w     = {{(CNT_W-1){1'b0}}, 1'b1} << limit_exp_w;
	assign done_o      = run_q && (count_q >= limit_w);

	// ==========================================================
	// Run flag: armed by a start, dropped by a clear
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			run_q <= 1'b0;
		end else if (clear_i) begin
			run_q <= 1'b0;
		end else if (start_i) begin
			run_q <= 1'b1;
		end
	end

	// Counts only real crystal edges after the oscillator has started,
	// and freezes at the selected wait so status never runs past it
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			count_q <= '0;
		end else if (clear_i || start_i) begin
			count_q <= '0;
		end else if (run_q && osc_started_i && tick_i && count_q < limit_w) begin
			count_q <= count_q + {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end

	// ==========================================================
	// Thermometer status, lowest step on the top bit
	for (genvar j = 0; j < mcsc_pkg::STAB_STEPS; j++) begin : g_step
		localparam logic [4:0] EXP_J = mcsc_pkg::STAB_EXP_TABLE[j*mcsc_pkg::STAB_EXP_W +: 5];
		assign status_o[7-j] = count_q >= ({{(CNT_W-1){1'b0}}, 1'b1} << EXP_J);
	end

	// ==========================================================
	// Checks
	chk_thermo_shape: assert property (@(posedge clk_i) disable iff (!resetn_i)
		((~status_o) & ((~status_o) + 8'h01)) == 8'h00)
		else $error("stabilization status is not a thermometer");

	chk_status_sticky: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(!clear_i && !start_i) |=> ((status_o & $past(status_o)) == $past(status_o)))
		else $error("stabilization status bit dropped without a clear");

	chk_limit_stop: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(run_q && count_q >= limit_w && !clear_i && !start_i && $stable(limit_sel_i))
		|=> $stable(count_q))
		else $error("stabilization count ran past the selected wait");

	chk_no_pre_osc: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(!osc_started_i && !clear_i && !start_i) |=> $stable(count_q))
		else $error("stabilization count moved before oscillation began");

endmodule

`default_nettype wire

// ---- bench/tb_top.sv ----
// Self-checking testbench for the main clock source control block.
`timescale 1ns/1ns
`default_nettype none

module tb_top;

	// ==========================================================
	// Stimulus and observed signals
	logic        clk;
	logic        resetn;
	logic [19:0] addr;
	logic        wr;
	logic        rd;
	logic [7:0]  wdata;
	logic [7:0]  rdata;
	logic        stop_enter;
	logic        stop_exit;
	logic        xtal_tick;
	logic        osc_started;
	logic        xtal_en;
	logic        gain;
	logic        ext_en;
	logic        x_port;
	logic        s_port;
	logic        onchip_run;
	logic        main_hs;
	logic        hs_ready;
	int          miscompares;
	int          samples_checked;

	mcsc_top mcsc_top_inst (
		.clk_i                    (clk),
		.resetn_i                 (resetn),
		.addr_i                   (addr),
		.wr_i                     (wr),
		.rd_i                     (rd),
		.wdata_i                  (wdata),
		.rdata_o                  (rdata),
		.stop_enter_i             (stop_enter),
		.stop_exit_i              (stop_exit),
		.xtal_tick_i              (xtal_tick),
		.osc_started_i            (osc_started),
		.xtal_osc_en_o            (xtal_en),
		.oscillator_gain_o        (gain),
		.ext_clk_en_o             (ext_en),
		.crystal_input_pin_port_o (x_port),
		.second_pin_port_o        (s_port),
		.onchip_osc_run_o         (onchip_run),
		.main_source_hs_o         (main_hs),
		.hs_clock_ready_o         (hs_ready)
	);

	// ==========================================================
	// Clock, 100 ns period
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// ==========================================================
	// Shared tasks; inputs always change 10 ns after the rising edge
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		if (miscompares == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Reset held for eight cycles, released just after an edge
	task automatic do_reset();
		resetn = 1'b0;
		repeat (8) @(posedge clk);
		#10 resetn = 1'b1;
	endtask

	task automatic bus_wr(input logic [19:0] a, input logic [7:0] d);
		@(posedge clk);
		#10 addr = a;
		wr = 1'b1;
		wdata = d;
		@(posedge clk);
		#10 wr = 1'b0;
	endtask

	// Read data is valid after the edge that samples the strobe
	task automatic bus_rd(input logic [19:0] a, input logic [7:0] exp);
		@(posedge clk);
		#10 addr = a;
		rd = 1'b1;
		@(posedge clk);
		#10 rd = 1'b0;
		check(rdata, exp);
	endtask

	// Exactly n edges see the crystal tick high
	task automatic ticks(input int n);
		@(posedge clk);
		#10 xtal_tick = 1'b1;
		repeat (n) @(posedge clk);
		#10 xtal_tick = 1'b0;
	endtask

	task automatic pulse(input bit is_exit);
		@(posedge clk);
		#10 stop_enter = !is_exit;
		stop_exit = is_exit;
		@(posedge clk);
		#10 stop_enter = 1'b0;
		stop_exit = 1'b0;
	endtask

	// ==========================================================
	// Watchdog sized well above the expected run of a few thousand cycles
	initial begin
		#(20000 * 100);
		miscompares++;
		complete_run();
	end

	// ==========================================================
	// Main sequence
	initial begin
		logic [1:0] m;
		miscompares = 0;
		samples_checked = 0;
		resetn = 1'b0;
		addr = 20'h00000;
		wr = 1'b0;
		rd = 1'b0;
		wdata = 8'h00;
		stop_enter = 1'b0;
		stop_exit = 1'b0;
		xtal_tick = 1'b0;
		osc_started = 1'b0;
		do_reset();
		// Reset values and read-only places
		bus_rd(mcsc_pkg::ADDR_PIN_MODE_AND_GAIN, 8'h00);
		bus_rd(mcsc_pkg::ADDR_CLOCK_RUN_STOP_CONTROL, 8'hc0);
		bus_rd(mcsc_pkg::ADDR_STABILIZATION_PROGRESS, 8'h00);
		bus_rd(mcsc_pkg::ADDR_STABILIZATION_TIME_SEL, 8'h07);
		bus_rd(mcsc_pkg::ADDR_MAIN_CLOCK_SELECT, 8'h00);
		check({onchip_run, x_port, s_port, xtal_en, ext_en}, 8'h1c);
		bus_wr(mcsc_pkg::ADDR_MAIN_CLOCK_SELECT, 8'h20);
		bus_rd(mcsc_pkg::ADDR_MAIN_CLOCK_SELECT, 8'h00);
		bus_wr(mcsc_pkg::ADDR_STABILIZATION_PROGRESS, 8'hff);
		bus_rd(mcsc_pkg::ADDR_STABILIZATION_PROGRESS, 8'h00);
		bus_wr(20'hfffa5, 8'h5a);
		bus_rd(20'hfffa5, 8'h00);
		// Every pin mode, run then stopped; one reset per mode
		for (int i = 0; i < 4; i++) begin
			m = i[1:0];
			do_reset();
			bus_wr(mcsc_pkg::ADDR_PIN_MODE_AND_GAIN, {m, 6'h00});
			bus_wr(mcsc_pkg::ADDR_CLOCK_RUN_STOP_CONTROL, 8'h40);
			check({x_port, s_port}, {6'h00, m != 2'b01, ~m[0]});
			check({xtal_en, ext_en}, {6'h00, m == 2'b01, m == 2'b11});
			bus_wr(mcsc_pkg::ADDR_CLOCK_RUN_STOP_CONTROL, 8'hc0);
			check({xtal_en, ext_en}, 8'h00);
		end
		// Crystal mode with high gain; the second write must not land
		do_reset();
		bus_wr(mcsc_pkg::ADDR_PIN_MODE_AND_GAIN, 8'h41);
		bus_wr(mcsc_pkg::ADDR_PIN_MODE_AND_GAIN, 8'h80);
		bus_rd(mcsc_pkg::ADDR_PIN_MODE_AND_GAIN, 8'h41);
		check(gain, 8'h01);
		bus_wr(mcsc_pkg::ADDR_STABILIZATION_TIME_SEL, 8'h00);
		bus_wr(mcsc_pkg::ADDR_CLOCK_RUN_STOP_CONTROL, 8'h40);
		// Ticks before oscillation starts are not counted
		ticks(300);
		bus_rd(mcsc_pkg::ADDR_STABILIZATION_PROGRESS, 8'h00);
		osc_started = 1'b1;
		ticks(255);
		bus_rd(mcsc_pkg::ADDR_STABILIZATION_PROGRESS, 8'h00);
		check(hs_ready, 8'h00);
		ticks(1);
		bus_rd(mcsc_pkg::ADDR_STABILIZATION_PROGRESS, 8'h80);
		check(hs_ready, 8'h01);
		ticks(600);
		bus_rd(mcsc_pkg::ADDR_STABILIZATION_PROGRESS, 8'h80);
		// Switch to the high-speed source, then stop the on-chip one
		bus_wr(mcsc_pkg::ADDR_MAIN_CLOCK_SELECT, 8'h10);
		bus_rd(mcsc_pkg::ADDR_MAIN_CLOCK_SELECT, 8'h30);
		check(main_hs, 8'h01);
		bus_wr(mcsc_pkg::ADDR_CLOCK_RUN_STOP_CONTROL, 8'h41);
		check(onchip_run, 8'h00);
		bus_wr(mcsc_pkg::ADDR_CLOCK_RUN_STOP_CONTROL, 8'h40);
		check(onchip_run, 8'h01);
		bus_wr(mcsc_pkg::ADDR_MAIN_CLOCK_SELECT, 8'h00);
		bus_rd(mcsc_pkg::ADDR_MAIN_CLOCK_SELECT, 8'h00);
		// Stopping the crystal clears progress
		bus_wr(mcsc_pkg::ADDR_CLOCK_RUN_STOP_CONTROL, 8'hc0);
		bus_rd(mcsc_pkg::ADDR_STABILIZATION_PROGRESS, 8'h00);
		check(xtal_en, 8'h00);
		// Longer selection: two steps, then frozen
		bus_wr(mcsc_pkg::ADDR_STABILIZATION_TIME_SEL, 8'h01);
		bus_wr(mcsc_pkg::ADDR_CLOCK_RUN_STOP_CONTROL, 8'h40);
		ticks(512);
		bus_rd(mcsc_pkg::ADDR_STABILIZATION_PROGRESS, 8'hc0);
		ticks(700);
		bus_rd(mcsc_pkg::ADDR_STABILIZATION_PROGRESS, 8'hc0);
		// STOP entry clears progress and gates the crystal; exit restarts the count
		pulse(1'b0);
		bus_rd(mcsc_pkg::ADDR_STABILIZATION_PROGRESS, 8'h00);
		check(xtal_en, 8'h00);
		pulse(1'b1);
		check(xtal_en, 8'h01);
		ticks(256);
		bus_rd(mcsc_pkg::ADDR_STABILIZATION_PROGRESS, 8'h80);
		ticks(256);
		bus_rd(mcsc_pkg::ADDR_STABILIZATION_PROGRESS, 8'hc0);
		complete_run();
	end

endmodule

`default_nettype wire
